// >>> logic/rsw_pkg.sv
package rsw_pkg;

   // Reset request sources, one bit each
   localparam int NSRC = 11;
   localparam int SRC_POR = 0;
   localparam int SRC_BROWNOUT = 1;
   localparam int SRC_PIN = 2;
   localparam int SRC_WATCHDOG = 3;
   localparam int SRC_CLK_LOSS = 4;
   localparam int SRC_LOCK_LOSS = 5;
   localparam int SRC_STOP_ACK = 6;
   localparam int SRC_SOFT = 7;
   localparam int SRC_LOCKUP = 8;
   localparam int SRC_DAP = 9;
   localparam int SRC_DEBUG = 10;

   // Reset destinations, one module reset each
   localparam int NMOD = 10;
   localparam int MOD_PWR = 0;
   localparam int MOD_SYS = 1;
   localparam int MOD_MODE = 2;
   localparam int MOD_RCTL = 3;
   localparam int MOD_PINREL = 4;
   localparam int MOD_WDT = 5;
   localparam int MOD_CLKGEN = 6;
   localparam int MOD_CAL = 7;
   localparam int MOD_LPT = 8;
   localparam int MOD_OTH = 9;

   // Source masks
   localparam logic [NSRC-1:0] MASK_ALL = 11'h7FF;
   localparam logic [NSRC-1:0] MASK_POR = 11'h001;
   localparam logic [NSRC-1:0] MASK_POR_BO = 11'h003;

   // Sources that reset a module as a whole
   localparam logic [NSRC-1:0] AFFECT [NMOD] = '{
      MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL,
      MASK_ALL, MASK_ALL, MASK_POR, MASK_POR_BO, MASK_ALL};

   // Sources that also reset the module's retained registers
   localparam logic [NSRC-1:0] FULL [NMOD] = '{
      MASK_POR, MASK_POR_BO, MASK_POR_BO, MASK_POR_BO, MASK_ALL,
      MASK_POR_BO, MASK_POR_BO, MASK_POR, MASK_POR_BO, MASK_ALL};

   // Power mode codes from the mode control unit
   localparam int MODE_W = 3;
   localparam logic [MODE_W-1:0] MODE_RUN = 3'h0;
   localparam logic [MODE_W-1:0] MODE_VLP_RUN = 3'h1;
   localparam logic [MODE_W-1:0] MODE_WAIT = 3'h2;
   localparam logic [MODE_W-1:0] MODE_VERY_LOW_POWER_WAIT = 3'h3;
   localparam logic [MODE_W-1:0] MODE_PARTIAL_STOP = 3'h4;
   localparam logic [MODE_W-1:0] MODE_FULL_STOP = 3'h5;
   localparam logic [MODE_W-1:0] MODE_VERY_LOW_POWER_STOP = 3'h6;

   // Reset release depth in core_clk edges
   localparam int SYNC_STAGES = 2;

   // Defaults for wake source counts
   localparam int PIN_IRQS = 8;
   localparam int PERIPH_WAKES = 8;

endpackage

// >>> logic/rsw_rst_sync.sv
`timescale 1ns/1ps
module rsw_rst_sync #(
   parameter int STAGES = 2
) (
   input wire logic clk,
   input wire logic arst_n,
   output logic rst_n
);

   logic [STAGES-1:0] chain_q;

   // Release needs at least two stages to settle
   if (STAGES < 2) begin : g_chk
      $error("rsw_rst_sync needs STAGES of 2 or more");
   end

   // Assert at once, release after STAGES edges
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         chain_q <= '0;
      end else begin
         chain_q <= {chain_q[STAGES-2:0], 1'b1};
      end
   end

   assign rst_n = chain_q[STAGES-1];

endmodule // rsw_rst_sync

// >>> logic/rsw_reset_wake.sv
// What this block does
// R1 - Each source resets its affected modules; excluded registers and others keep state.
// R2 - System sources other than power-on never reset the calendar timekeeper.
// R3 - Debug-port reset clears power, integration, mode, reset units; spares calendar, timer.
// R4 - In deep stop, wake events are seen without a clock and restart clocking.
// R5 - After clocks restart the interrupt controller sees the pending interrupt.
// R6 - The wake detector works in partial stop, full stop and low-power stop.
// R7 - Any enabled pin interrupt wakes the device from stop states.
// R8 - Clock generator wakes only in full stop with the slow oscillator selected.
// R9 - Pin, watchdog, clock-loss and lock-loss resets also wake from stop.
// R10 - In wait states the interrupt controller, not the wake detector, wakes the core.
// R11 - In full stop the interrupt controller is off; wakes pass the detector.
// R12 - Module resets assert asynchronously and release synchronously after sources end.
`timescale 1ns/1ps
module rsw_reset_wake
   import rsw_pkg::*;
#(
   parameter int N_PIN = PIN_IRQS,
   parameter int N_PERIPH = PERIPH_WAKES
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic src_brownout,
   input wire logic src_pin,
   input wire logic src_watchdog,
   input wire logic src_clk_loss,
   input wire logic src_lock_loss,
   input wire logic src_stop_ack,
   input wire logic src_soft,
   input wire logic src_lockup,
   input wire logic src_dap,
   input wire logic src_debug,
   input wire logic [MODE_W-1:0] power_mode,
   input wire logic [N_PIN-1:0] pin_irq_pend,
   input wire logic [N_PIN-1:0] pin_irq_en,
   input wire logic [N_PERIPH-1:0] periph_wake,
   input wire logic clk_gen_wake,
   input wire logic slow_osc_sel,
   output logic [NMOD-1:0] mod_rst_n,
   output logic [NMOD-1:0] excl_rst_n,
   output logic clk_wake_req,
   output logic irq_ctrl_en,
   output logic [N_PIN+N_PERIPH-1:0] irq_pend
);

   localparam int NPEND = N_PIN + N_PERIPH;

   if (N_PIN < 1 || N_PERIPH < 1) begin : g_chk
      $error("rsw_reset_wake needs at least one pin and one peripheral");
   end

   // True when any source in the mask is requesting
   function automatic logic hits(input logic [NSRC-1:0] req,
                                 input logic [NSRC-1:0] mask);
      hits = |(req & mask);
   endfunction

   logic [NSRC-1:0] src_req;
   logic [NMOD-1:0] mod_hit;
   logic [NMOD-1:0] excl_hit;
   logic in_deep_stop;
   logic in_full_stop;
   logic in_wait_class;
   logic pin_wake;
   logic sys_rst_wake;
   logic clkgen_wake_ok;
   logic other_wake;
   logic wake_async;
   logic wake_q;
   logic irq_en_q;
   logic [NPEND-1:0] pend_s1_q;
   logic [NPEND-1:0] pend_s2_q;
   logic [NPEND-1:0] irq_pend_q;

   // Gather all reset requests, power-on from the core reset
   assign src_req = {src_debug, src_dap, src_lockup, src_soft,
                     src_stop_ack, src_lock_loss, src_clk_loss,
                     src_watchdog, src_pin, src_brownout, ~reset_n};

   // Per-module reset fan-out through the source masks
   for (genvar m = 0; m < NMOD; m++) begin : g_mod
      assign mod_hit[m] = hits(src_req, AFFECT[m]); // [R1] [R2] [R3]
      assign excl_hit[m] = hits(src_req, FULL[m]); // [R1]

      rsw_rst_sync #(
         .STAGES(SYNC_STAGES)
      ) u_mod_sync (
         .clk(core_clk),
         .arst_n(~mod_hit[m]), // [R12]
         .rst_n(mod_rst_n[m])
      );

      rsw_rst_sync #(
         .STAGES(SYNC_STAGES)
      ) u_excl_sync (
         .clk(core_clk),
         .arst_n(~excl_hit[m]), // [R12]
         .rst_n(excl_rst_n[m])
      );
   end

   // Mode decode
   assign in_full_stop = (power_mode == MODE_FULL_STOP);
   assign in_deep_stop = (power_mode == MODE_PARTIAL_STOP) ||
                         in_full_stop ||
                         (power_mode == MODE_VERY_LOW_POWER_STOP); // [R6]
   assign in_wait_class = (power_mode == MODE_WAIT) ||
                          (power_mode == MODE_VERY_LOW_POWER_WAIT);

   // Clockless wake sources, read raw since no clock runs
   assign pin_wake = |(pin_irq_pend & pin_irq_en); // [R7]
   assign sys_rst_wake = src_pin | src_watchdog | src_clk_loss |
                         src_lock_loss; // [R9]
   assign clkgen_wake_ok = clk_gen_wake & in_full_stop &
                           slow_osc_sel; // [R8]
   assign other_wake = pin_wake | sys_rst_wake | (|periph_wake);

   // Detector armed only in stop states, never in wait states
   assign wake_async = in_deep_stop &
                       (other_wake | clkgen_wake_ok); // [R4] [R10]

   // Wake request sets without a clock, clears once out of stop
   always_ff @(posedge core_clk or negedge reset_n or
               posedge wake_async) begin
      if (!reset_n) begin
         wake_q <= 1'b0;
      end else if (wake_async) begin
         wake_q <= 1'b1; // [R4]
      end else if (!in_deep_stop) begin
         wake_q <= 1'b0;
      end
   end

   // Interrupt controller off in full and low-power stop
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_en_q <= 1'b1;
      end else begin
         irq_en_q <= !(in_full_stop ||
                       power_mode == MODE_VERY_LOW_POWER_STOP); // [R11]
      end
   end

   // Pending lines synchronised for the interrupt controller
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_s1_q <= '0;
         pend_s2_q <= '0;
         irq_pend_q <= '0;
      end else begin
         pend_s1_q <= {periph_wake, pin_irq_pend};
         pend_s2_q <= pend_s1_q;
         irq_pend_q <= pend_s2_q &
                       {{N_PERIPH{1'b1}}, pin_irq_en}; // [R5]
      end
   end

   assign clk_wake_req = wake_q;
   assign irq_ctrl_en = irq_en_q;
   assign irq_pend = irq_pend_q;

   // Checks on reset fan-out and wake behaviour
   property p_src_asserts;
      @(posedge core_clk) disable iff (!reset_n)
         src_watchdog |=> !mod_rst_n[MOD_OTH] && !mod_rst_n[MOD_SYS];
   endproperty
   a_src_asserts: assert property (p_src_asserts) // [R1]
      else $error("watchdog source did not reset its modules");

   property p_cal_spared;
      @(posedge core_clk) disable iff (!reset_n)
         mod_rst_n[MOD_CAL] && (|src_req[NSRC-1:SRC_BROWNOUT]) |=>
            mod_rst_n[MOD_CAL] && excl_rst_n[MOD_CAL];
   endproperty
   a_cal_spared: assert property (p_cal_spared) // [R2]
      else $error("calendar reset by a system source");

   property p_dap_reset;
      @(posedge core_clk) disable iff (!reset_n)
         src_dap && !src_brownout && mod_rst_n[MOD_LPT] |=>
            !mod_rst_n[MOD_PWR] && !mod_rst_n[MOD_SYS] &&
            !mod_rst_n[MOD_MODE] && !mod_rst_n[MOD_RCTL] &&
            mod_rst_n[MOD_LPT] && mod_rst_n[MOD_CAL];
   endproperty
   a_dap_reset: assert property (p_dap_reset) // [R3]
      else $error("debug-port reset hit the wrong modules");

   property p_release;
      @(posedge core_clk) disable iff (!reset_n)
         (!mod_hit[MOD_OTH] && $past(mod_hit[MOD_OTH])) ##0
            !mod_rst_n[MOD_OTH] ##1 !mod_hit[MOD_OTH] [*2] |->
            mod_rst_n[MOD_OTH];
   endproperty
   a_release: assert property (p_release) // [R12]
      else $error("module reset not released two edges after sources");

   property p_early_release;
      @(posedge core_clk) disable iff (!reset_n)
         $past(mod_hit[MOD_PWR]) |-> !mod_rst_n[MOD_PWR];
   endproperty
   a_early_release: assert property (p_early_release) // [R12]
      else $error("module reset released too early");

   property p_stop_wake;
      @(posedge core_clk) disable iff (!reset_n)
         in_deep_stop && (|periph_wake) |=> clk_wake_req;
   endproperty
   a_stop_wake: assert property (p_stop_wake) // [R4]
      else $error("no clock wake request in deep stop");

   property p_pin_wake;
      @(posedge core_clk) disable iff (!reset_n)
         in_deep_stop && |(pin_irq_pend & pin_irq_en) ##1 in_deep_stop
            |-> clk_wake_req;
   endproperty
   a_pin_wake: assert property (p_pin_wake) // [R7]
      else $error("enabled pin interrupt did not wake");

   property p_rst_wake;
      @(posedge core_clk) disable iff (!reset_n)
         in_deep_stop && src_clk_loss ##1 in_deep_stop |-> clk_wake_req;
   endproperty
   a_rst_wake: assert property (p_rst_wake) // [R9]
      else $error("clock-loss reset did not wake");

   property p_clkgen_only;
      @(posedge core_clk) disable iff (!reset_n)
         !clk_wake_req ##1 (!other_wake && !(in_full_stop && slow_osc_sel))
            |-> !clk_wake_req;
   endproperty
   a_clkgen_only: assert property (p_clkgen_only) // [R8]
      else $error("clock generator woke outside full stop");

   property p_wait_no_detect;
      @(posedge core_clk) disable iff (!reset_n)
         in_wait_class ##1 in_wait_class |-> !clk_wake_req;
   endproperty
   a_wait_no_detect: assert property (p_wait_no_detect) // [R10]
      else $error("wake detector active in a wait state");

   property p_irq_off;
      @(posedge core_clk) disable iff (!reset_n)
         in_full_stop |=> !irq_ctrl_en;
   endproperty
   a_irq_off: assert property (p_irq_off) // [R11]
      else $error("interrupt controller left on in full stop");

   property p_pend_fwd;
      @(posedge core_clk) disable iff (!reset_n)
         periph_wake[0] [*3] |=> irq_pend[N_PIN];
   endproperty
   a_pend_fwd: assert property (p_pend_fwd) // [R5]
      else $error("pending wake not shown to interrupt controller");

   // Main scenarios
   c_dap: cover property (@(posedge core_clk) disable iff (!reset_n)
      src_dap ##1 !mod_rst_n[MOD_RCTL]);
   c_stop_wake: cover property (@(posedge core_clk) disable iff (!reset_n)
      in_full_stop ##1 clk_wake_req ##[1:20] irq_ctrl_en);
   c_clkgen: cover property (@(posedge core_clk) disable iff (!reset_n)
      clkgen_wake_ok ##1 clk_wake_req);
   c_release: cover property (@(posedge core_clk) disable iff (!reset_n)
      $rose(mod_rst_n[MOD_LPT]));

endmodule // rsw_reset_wake

// >>> testbench/rsw_clk_ctl_model.sv
`timescale 1ns/1ps
// Clock and mode control stand-in on the far side of the wake path
module rsw_clk_ctl_model
   import rsw_pkg::*;
#(
   parameter int WAKE_DLY = 4
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic mode_go,
   input wire logic [MODE_W-1:0] req_mode,
   input wire logic clk_wake_req,
   output logic [MODE_W-1:0] power_mode
);
   logic [7:0] cnt_q;
   logic in_stop;

   // Stop modes, where clocks wait for the wake request
   assign in_stop = power_mode >= MODE_PARTIAL_STOP;

   // Enter requested mode; resume run a few cycles after a wake
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         power_mode <= MODE_RUN;
         cnt_q <= 8'h00;
      end else if (mode_go) begin
         power_mode <= req_mode;
         cnt_q <= 8'h00;
      end else if (clk_wake_req && in_stop) begin
         if (cnt_q == 8'(WAKE_DLY)) begin
            power_mode <= MODE_RUN;
         end
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule // rsw_clk_ctl_model

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import rsw_pkg::*;
   localparam int NP = PIN_IRQS;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [NSRC-1:0] src = '0;
   logic [NP-1:0] pend = '0;
   logic [NP-1:0] en = '0;
   logic [PERIPH_WAKES-1:0] pw = '0;
   logic cg = 1'b0;
   logic slow = 1'b0;
   logic go = 1'b0;
   logic [MODE_W-1:0] req = MODE_RUN;
   logic [MODE_W-1:0] power_mode;
   logic [NMOD-1:0] mod_rst_n;
   logic [NMOD-1:0] excl_rst_n;
   logic clk_wake_req;
   logic irq_ctrl_en;
   logic [NP+PERIPH_WAKES-1:0] irq_pend;
   int errors = 0;
   int n_compared = 0;

   always #2.5 core_clk = ~core_clk;

   rsw_reset_wake uut (.core_clk(core_clk), .reset_n(reset_n),
      .src_brownout(src[1]), .src_pin(src[2]), .src_watchdog(src[3]),
      .src_clk_loss(src[4]), .src_lock_loss(src[5]),
      .src_stop_ack(src[6]), .src_soft(src[7]), .src_lockup(src[8]),
      .src_dap(src[9]), .src_debug(src[10]), .power_mode(power_mode),
      .pin_irq_pend(pend), .pin_irq_en(en), .periph_wake(pw),
      .clk_gen_wake(cg), .slow_osc_sel(slow), .mod_rst_n(mod_rst_n),
      .excl_rst_n(excl_rst_n), .clk_wake_req(clk_wake_req),
      .irq_ctrl_en(irq_ctrl_en), .irq_pend(irq_pend));

   rsw_clk_ctl_model partner (.core_clk(core_clk), .reset_n(reset_n),
      .mode_go(go), .req_mode(req), .clk_wake_req(clk_wake_req),
      .power_mode(power_mode));

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // Mode reaches the block one edge after the request
   task automatic set_mode(input logic [MODE_W-1:0] m);
      @(posedge core_clk);
      req <= m;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      #1;
   endtask

   task automatic test_fanout;
      logic [NMOD-1:0] em;
      logic [NMOD-1:0] ex;
      for (int s = 1; s < NSRC; s++) begin
         @(posedge core_clk);
         src <= NSRC'(1) << s;
         #1;
         for (int m = 0; m < NMOD; m++) begin
            em[m] = ~AFFECT[m][s];
            ex[m] = ~FULL[m][s];
         end
         chk("mod_rst_n", mod_rst_n, em);
         chk("excl_rst_n", excl_rst_n, ex);
         @(posedge core_clk);
         src <= '0;
         tick(1);
         chk("mod_rst_n hold", mod_rst_n, em);
         tick(1);
         chk("mod_rst_n free", mod_rst_n, {NMOD{1'b1}});
      end
      $display("test fanout done");
   endtask

   task automatic test_wake;
      @(posedge core_clk);
      pend[0] <= 1'b1;
      set_mode(MODE_FULL_STOP);
      chk("wake off", clk_wake_req, 0);
      @(posedge core_clk);
      en[0] <= 1'b1;
      #1;
      chk("wake on", clk_wake_req, 1);
      for (int m = 0; m < 7; m++) begin
         set_mode(MODE_W'(m));
         tick(1);
         chk("wake", clk_wake_req, m >= 4);
         chk("irq_ctrl_en", irq_ctrl_en, m < 5);
      end
      @(posedge core_clk);
      pend[0] <= 1'b0;
      set_mode(MODE_RUN);
      tick(1);
      chk("wake clear", clk_wake_req, 0);
      $display("test wake done");
   endtask

   task automatic test_clkgen;
      @(posedge core_clk);
      cg <= 1'b1;
      for (int m = 4; m < 7; m++) begin
         for (int s = 0; s < 2; s++) begin
            set_mode(MODE_RUN);
            @(posedge core_clk);
            slow <= s[0];
            set_mode(MODE_W'(m));
            chk("clkgen wake", clk_wake_req, m == 5 && s == 1);
         end
      end
      @(posedge core_clk);
      cg <= 1'b0;
      set_mode(MODE_RUN);
      $display("test clkgen done");
   endtask

   task automatic test_rst_wake;
      int rs[4] = '{SRC_PIN, SRC_WATCHDOG, SRC_CLK_LOSS, SRC_LOCK_LOSS};
      foreach (rs[i]) begin
         set_mode(MODE_RUN);
         tick(1);
         set_mode(MODE_VERY_LOW_POWER_STOP);
         @(posedge core_clk);
         src <= NSRC'(1) << rs[i];
         #1;
         chk("reset wake", clk_wake_req, 1);
         @(posedge core_clk);
         src <= '0;
         tick(3);
      end
      $display("test reset wake done");
   endtask

   task automatic test_resume;
      int k;
      set_mode(MODE_RUN);
      tick(1);
      set_mode(MODE_FULL_STOP);
      tick(1);
      chk("irq off", irq_ctrl_en, 0);
      @(posedge core_clk);
      pw[0] <= 1'b1;
      #1;
      chk("periph wake", clk_wake_req, 1);
      for (k = 0; k < 20 && power_mode !== MODE_RUN; k++) tick(1);
      if (k == 20) begin
         chk("resume mode", power_mode, MODE_RUN);
         stop_test();
      end
      tick(1);
      chk("irq on", irq_ctrl_en, 1);
      chk("periph pend", irq_pend[NP], 1);
      @(posedge core_clk);
      pend[3] <= 1'b1;
      en[3] <= 1'b1;
      tick(2);
      chk("pin pend early", irq_pend[3], 0);
      tick(1);
      chk("pin pend", irq_pend[3], 1);
      @(posedge core_clk);
      pw <= '0;
      pend <= '0;
      $display("test resume done");
   endtask

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge core_clk);
      #1;
      chk("por mod", mod_rst_n, 0);
      chk("por excl", excl_rst_n, 0);
      @(posedge core_clk);
      reset_n <= 1'b1;
      tick(3);
      chk("released", mod_rst_n, {NMOD{1'b1}});
      test_fanout();
      test_wake();
      test_clkgen();
      test_rst_wake();
      test_resume();
      stop_test();
   end
endmodule // testbench
